// [common/mitd_pkg.sv]
// mitd_pkg.sv: types shared by the instruction timing decoder
// assumes mitd_regs.svh supplies the numeric constants
package mitd_pkg;

	// timing answer for one opcode
	typedef struct packed {
		logic       valid;
		logic [1:0] length;
		logic [3:0] cyc_taken;
		logic [3:0] cyc_not_taken;
		logic       conditional;
		logic       ext_data;
		logic       code_read;
		logic       ext_write;
		logic       rel_offset;
		logic       clears_bit;
	} mitd_info_t;

	typedef enum logic [1:0] {
		MITD_IDLE,
		MITD_HOLD
	} mitd_state_t;

	typedef struct packed {
		mitd_state_t state;
		mitd_info_t  info;
	} mitd_regs_t;

endpackage

// [common/mitd_regs.svh]
// mitd_regs.svh: opcode encodings and cycle counts for the decoder
// assumes the standard 8051 opcode map
`ifndef MITD_REGS_SVH
`define MITD_REGS_SVH

// ----------------------------------------------------------------------
// opcode encodings with special timing
// ----------------------------------------------------------------------
`define MITD_OP_NOP        8'h00
`define MITD_OP_SPARE      8'ha5
`define MITD_OP_MUL        8'ha4
`define MITD_OP_DIV        8'h84
`define MITD_OP_DP_LOAD    8'h90
`define MITD_OP_DP_INC     8'ha3
`define MITD_OP_CODE_DP    8'h93
`define MITD_OP_CODE_PC    8'h83
`define MITD_OP_JMP_IND    8'h73
`define MITD_OP_RET        8'h22
`define MITD_OP_IRET       8'h32
`define MITD_OP_LONG_CALL      8'h12
`define MITD_OP_LONG_JUMP       8'h02
`define MITD_OP_SHORT_JUMP       8'h80
`define MITD_OP_COMPARE_JUMP_NE_IND0  8'hb6
`define MITD_OP_COMPARE_JUMP_NE_IND1  8'hb7

// ----------------------------------------------------------------------
// cycle counts
// ----------------------------------------------------------------------
`define MITD_CYC_MUL       4'h4
`define MITD_CYC_DIV       4'h8
`define MITD_CYC_RET       4'h5
`define MITD_CYC_XDATA     4'h3

`endif

// [hdl/mitd_decoder.sv]
// mitd_decoder.sv: per-opcode byte length and cycle count for the pipeline
// assumes the fetch unit presents one opcode with a one-cycle strobe
`timescale 1ns/1ps
`include "mitd_regs.svh"

// Operation
// RULE_01: external data moves are flagged for routing to program flash
// RULE_02: no external memory bus ports exist; all accesses are on-chip
// RULE_03: add, add-carry, subtract-borrow per operand; multiply 4, divide 8
// RULE_04: AND, OR, XOR into accumulator: register 1, others 2 cycles
// RULE_05: logic to direct: accumulator source 2/2, immediate source 3/3
// RULE_06: accumulator-only ops and simple increments take one byte, one cycle
// RULE_07: moves: register 1, direct/immediate 2, direct-direct 3, indirect 2
// RULE_08: data pointer load is 3 bytes, 3 cycles
// RULE_09: code byte reads are 1 byte, 3 cycles
// RULE_10: all four external data move forms are 1 byte, 3 cycles
// RULE_11: push and pop are 2 bytes, 2 cycles
// RULE_12: exchanges: register 1 cycle, direct 2, indirect 2, nibble 2
// RULE_13: carry ops 1/1; direct bit operations 2 bytes, 2 cycles
// RULE_14: carry and zero jumps are 2 bytes, 2 or 3 cycles
// RULE_15: bit jumps 3 bytes, 3 or 4 cycles; test-clear variant clears
// RULE_16: compare-jump 3 bytes, 3/4 cycles, indirect form 4/5
// RULE_17: decrement-jump register 2 bytes 2/3, direct 3 bytes 3/4
// RULE_18: absolute 2/3, short and indirect jump 3, long 3/4, returns 1/5
// RULE_19: not-taken branch takes one cycle fewer than taken
// RULE_20: relative offsets flagged as signed bytes from next instruction
// RULE_21: the spare opcode decodes exactly like no-operation
// RULE_22: length and taken/not-taken counts presented per fetched opcode
module mitd_decoder (
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                op_valid,
	input  wire logic [7:0]          opcode,
	output mitd_pkg::mitd_info_t     info
);

	mitd_pkg::mitd_regs_t r;
	mitd_pkg::mitd_regs_t next_r;

	// ------------------------------------------------------------------
	// decode function
	// ------------------------------------------------------------------
	// the table serves the live answer only; the assertions hold their own expected values
	function automatic mitd_pkg::mitd_info_t decode(input logic [7:0] op);
		mitd_pkg::mitd_info_t d;
		logic [3:0] lo;
		logic [3:0] hi;
		d = '0;
		lo = op[3:0];
		hi = op[7:4];
		d.valid = 1'b1;
		d.length = 2'h1;
		d.cyc_taken = 4'h1;
		if (lo >= 4'h8) begin
			// register forms
			case (hi)
				4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9,
				4'hc, 4'he, 4'hf: begin
					d.cyc_taken = 4'h1; // RULE_03 RULE_04 RULE_06 RULE_07 RULE_12
				end
				4'h7, 4'ha: begin
					d.length = 2'h2; // RULE_07
					d.cyc_taken = 4'h2;
				end
				4'h8: begin
					d.length = 2'h2;
					d.cyc_taken = 4'h2; // RULE_07
				end
				4'hb: begin
					d.length = 2'h3; // RULE_16
					d.cyc_taken = 4'h4;
					d.conditional = 1'b1;
					d.rel_offset = 1'b1;
				end
				4'hd: begin
					d.length = 2'h2; // RULE_17
					d.cyc_taken = 4'h3;
					d.conditional = 1'b1;
					d.rel_offset = 1'b1;
				end
				default: d.cyc_taken = 4'h1;
			endcase
		end else if (lo == 4'h6 || lo == 4'h7) begin
			// indirect forms
			d.cyc_taken = 4'h2; // RULE_03 RULE_04 RULE_07 RULE_12
			case (hi)
				4'h7, 4'ha: d.length = 2'h2; // RULE_07
				4'h8: d.length = 2'h2;
				4'hb: begin
					d.length = 2'h3; // RULE_16
					d.cyc_taken = 4'h5;
					d.conditional = 1'b1;
					d.rel_offset = 1'b1;
				end
				4'hd: d.cyc_taken = 4'h2; // RULE_12
				// e6/e7 and f6/f7 are plain accumulator moves through an
				// index register; only the x0/x2/x3 codes reach program flash
				4'he, 4'hf: d.cyc_taken = 4'h2; // RULE_07
				default: d.cyc_taken = 4'h2;
			endcase
		end else if (lo == 4'h1) begin
			d.length = 2'h2; // RULE_18
			d.cyc_taken = 4'h3;
		end else begin
			case (op)
				`MITD_OP_NOP, `MITD_OP_SPARE: d.cyc_taken = 4'h1; // RULE_21
				`MITD_OP_LONG_JUMP, `MITD_OP_LONG_CALL: begin
					d.length = 2'h3; // RULE_18
					d.cyc_taken = 4'h4;
				end
				`MITD_OP_RET, `MITD_OP_IRET: d.cyc_taken = `MITD_CYC_RET; // RULE_18
				`MITD_OP_SHORT_JUMP: begin
					d.length = 2'h2; // RULE_18
					d.cyc_taken = 4'h3;
					d.rel_offset = 1'b1; // RULE_20
				end
				`MITD_OP_JMP_IND: d.cyc_taken = 4'h3; // RULE_18
				`MITD_OP_MUL: d.cyc_taken = `MITD_CYC_MUL; // RULE_03
				`MITD_OP_DIV: d.cyc_taken = `MITD_CYC_DIV; // RULE_03
				`MITD_OP_DP_LOAD: begin
					d.length = 2'h3; // RULE_08
					d.cyc_taken = 4'h3;
				end
				`MITD_OP_DP_INC: d.cyc_taken = 4'h1; // RULE_06
				`MITD_OP_CODE_DP, `MITD_OP_CODE_PC: begin
					d.cyc_taken = 4'h3; // RULE_09
					d.code_read = 1'b1; // RULE_01
				end
				8'he0, 8'he2, 8'he3: begin
					d.cyc_taken = `MITD_CYC_XDATA; // RULE_10
					d.ext_data = 1'b1; // RULE_01
				end
				8'hf0, 8'hf2, 8'hf3: begin
					d.cyc_taken = `MITD_CYC_XDATA; // RULE_10
					d.ext_data = 1'b1;
					d.ext_write = 1'b1; // RULE_01
				end
				8'h10, 8'h20, 8'h30: begin
					d.length = 2'h3; // RULE_15
					d.cyc_taken = 4'h4;
					d.conditional = 1'b1;
					d.rel_offset = 1'b1;
					d.clears_bit = (op == 8'h10); // RULE_15
				end
				8'h40, 8'h50, 8'h60, 8'h70: begin
					d.length = 2'h2; // RULE_14
					d.cyc_taken = 4'h3;
					d.conditional = 1'b1;
					d.rel_offset = 1'b1; // RULE_20
				end
				8'hb4, 8'hb5: begin
					d.length = 2'h3; // RULE_16
					d.cyc_taken = 4'h4;
					d.conditional = 1'b1;
					d.rel_offset = 1'b1;
				end
				8'hd5: begin
					d.length = 2'h3; // RULE_17
					d.cyc_taken = 4'h4;
					d.conditional = 1'b1;
					d.rel_offset = 1'b1;
				end
				8'h43, 8'h53, 8'h63: begin
					d.length = 2'h3; // RULE_05
					d.cyc_taken = 4'h3;
				end
				8'h75, 8'h85: begin
					d.length = 2'h3; // RULE_07
					d.cyc_taken = 4'h3;
				end
				// one-byte one-cycle accumulator and carry ops
				8'h03, 8'h04, 8'h13, 8'h14, 8'h23, 8'h33, 8'hc3, 8'hd3,
				8'hb3, 8'hc4, 8'hd4, 8'he4, 8'hf4: begin
					d.cyc_taken = 4'h1; // RULE_06 RULE_13
				end
				default: begin
					// remaining opcodes are two-byte two-cycle
					d.length = 2'h2; // RULE_03 RULE_04 RULE_05 RULE_11 RULE_13
					d.cyc_taken = 4'h2;
				end
			endcase
		end
		// not-taken is one less for conditional branches, same otherwise
		if (d.conditional) begin
			d.cyc_not_taken = d.cyc_taken - 4'h1; // RULE_19
		end else begin
			d.cyc_not_taken = d.cyc_taken;
		end
		return d;
	endfunction

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	// answer fields held until the next opcode so the sequencer may sample late; valid lasts one cycle
	always_comb begin
		next_r = r;
		next_r.info.valid = 1'b0;
		if (op_valid) begin
			next_r.info = decode(opcode); // RULE_22
			next_r.state = mitd_pkg::MITD_HOLD;
		end else begin
			case (r.state)
				mitd_pkg::MITD_IDLE: next_r.state = mitd_pkg::MITD_IDLE;
				mitd_pkg::MITD_HOLD: next_r.state = mitd_pkg::MITD_HOLD;
				default: next_r.state = mitd_pkg::MITD_IDLE;
			endcase
		end
	end

	// register stage; synchronous reset clears the answer
	always_ff @(posedge core_clk) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign info = r.info; // RULE_02

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_answer_follows;
		@(posedge core_clk) disable iff (rst)
		op_valid |=> info.valid;
	endproperty
	a_answer_follows: assert property (p_answer_follows) // RULE_22
		else $error("no answer after opcode");

	property p_not_taken_less;
		@(posedge core_clk) disable iff (rst)
		info.valid && info.conditional |->
			info.cyc_not_taken + 4'h1 == info.cyc_taken &&
			info.cyc_taken >= 4'h3 && info.cyc_taken <= 4'h5 && info.rel_offset;
	endproperty
	a_not_taken_less: assert property (p_not_taken_less) // RULE_19
		else $error("branch not-taken count wrong");

	property p_div_eight;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode == `MITD_OP_DIV |=> info.cyc_taken == 4'h8;
	endproperty
	a_div_eight: assert property (p_div_eight) // RULE_03
		else $error("divide count wrong");

	property p_xdata_flash;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode[7:5] == 3'h7 && opcode[3:1] == 3'h1 |=>
			info.ext_data && info.cyc_taken == 4'h3 && info.length == 2'h1;
	endproperty
	a_xdata_flash: assert property (p_xdata_flash) // RULE_10
		else $error("external move not routed");

	property p_spare_nop;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode == `MITD_OP_SPARE |=>
			info.length == 2'h1 && info.cyc_taken == 4'h1;
	endproperty
	a_spare_nop: assert property (p_spare_nop) // RULE_21
		else $error("spare opcode not nop");

	property p_compare_jump_ne_ind;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode[7:1] == 7'h5b |=>
			info.cyc_taken == 4'h5 && info.length == 2'h3;
	endproperty
	a_compare_jump_ne_ind: assert property (p_compare_jump_ne_ind) // RULE_16
		else $error("indirect compare-jump wrong");

	property p_return_five;
		@(posedge core_clk) disable iff (rst)
		op_valid && (opcode == `MITD_OP_RET || opcode == `MITD_OP_IRET) |=>
			info.cyc_taken == 4'h5;
	endproperty
	a_return_five: assert property (p_return_five) // RULE_18
		else $error("return count wrong");

	property p_reg_add;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode[7:5] == 3'h1 && opcode[3] |=>
			info.cyc_taken == 4'h1 && info.length == 2'h1;
	endproperty
	a_reg_add: assert property (p_reg_add) // RULE_03
		else $error("register add count wrong");

	property p_dp_load;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode == `MITD_OP_DP_LOAD |=>
			info.length == 2'h3 ##0 info.cyc_taken == 4'h3;
	endproperty
	a_dp_load: assert property (p_dp_load) // RULE_08
		else $error("pointer load wrong");

	// an indirect plain move must not be mistaken for a flash access
	property p_ind_move;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode[7:5] == 3'h7 && opcode[3:1] == 3'h3 |=>
			!info.ext_data && info.cyc_taken == 4'h2 && info.length == 2'h1;
	endproperty
	a_ind_move: assert property (p_ind_move) // RULE_07
		else $error("indirect move misrouted");

	property p_bit_clear_jump;
		@(posedge core_clk) disable iff (rst)
		op_valid && opcode == 8'h10 |=>
			info.clears_bit && info.conditional && info.length == 2'h3;
	endproperty
	a_bit_clear_jump: assert property (p_bit_clear_jump) // RULE_15
		else $error("test-clear jump wrong");

endmodule

// [testbench/mcu_instruction_timing_tb_top.sv]
// mcu_instruction_timing_tb_top.sv: self-checking bench for the decoder
// assumes answers arrive exactly one cycle after each strobe
`timescale 1ns/1ps
module mcu_instruction_timing_tb_top;
	logic                 core_clk;
	logic                 rst;
	logic                 req;
	logic [7:0]           req_op;
	logic                 op_valid;
	logic [7:0]           opcode;
	mitd_pkg::mitd_info_t info;
	int                   mismatches;
	int                   checks;
	logic [7:0]           ones [11] = '{8'he4, 8'hf4, 8'h23, 8'h33, 8'h03,
		8'h13, 8'hc4, 8'hd4, 8'h04, 8'h18, 8'ha3};
	logic [7:0]           exts [4] = '{8'he2, 8'hf2, 8'he0, 8'hf0};

	// ----------------------------------------------------------------
	// design and fetch model
	// ----------------------------------------------------------------
	mitd_fetch_model u_fetch (.core_clk(core_clk), .req(req),
		.req_op(req_op), .op_valid(op_valid), .opcode(opcode));
	mitd_decoder u_dut (.core_clk(core_clk), .rst(rst),
		.op_valid(op_valid), .opcode(opcode), .info(info));

	// 125 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic cmp(input string w, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", w, e, g);
		end
	endtask

	// one strobe, answer checked in its cycle, then valid low and held taken count checked
	task automatic op(input logic [7:0] o, input logic [1:0] l,
		input logic [3:0] t, input logic [3:0] n);
		req = 1'b1;
		req_op = o;
		@(negedge core_clk);
		req = 1'b0;
		cmp("valid", 8'h1, info.valid);
		cmp("length", l, info.length);
		cmp("taken", t, info.cyc_taken);
		cmp("not_taken", n, info.cyc_not_taken);
		cmp("conditional", t != n, info.conditional);
		@(negedge core_clk);
		cmp("valid_low", 8'h0, info.valid);
		cmp("held", t, info.cyc_taken);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_arith();
		op(8'h28, 2'h1, 4'h1, 4'h1);
		op(8'h35, 2'h2, 4'h2, 4'h2);
		op(8'h96, 2'h1, 4'h2, 4'h2);
		op(8'h94, 2'h2, 4'h2, 4'h2);
		op(8'ha4, 2'h1, 4'h4, 4'h4);
		op(8'h84, 2'h1, 4'h8, 4'h8);
		op(8'h58, 2'h1, 4'h1, 4'h1);
		op(8'h46, 2'h1, 4'h2, 4'h2);
		op(8'h64, 2'h2, 4'h2, 4'h2);
		op(8'h52, 2'h2, 4'h2, 4'h2);
		op(8'h43, 2'h3, 4'h3, 4'h3);
		op(8'h63, 2'h3, 4'h3, 4'h3);
		foreach (ones[i]) op(ones[i], 2'h1, 4'h1, 4'h1);
	endtask

	task automatic t_move();
		op(8'he8, 2'h1, 4'h1, 4'h1);
		op(8'he5, 2'h2, 4'h2, 4'h2);
		op(8'h85, 2'h3, 4'h3, 4'h3);
		op(8'h75, 2'h3, 4'h3, 4'h3);
		op(8'hf6, 2'h1, 4'h2, 4'h2);
		cmp("ind_ext", 8'h0, info.ext_data);
		op(8'h90, 2'h3, 4'h3, 4'h3);
		cmp("dp_code", 8'h0, info.code_read);
		op(8'h83, 2'h1, 4'h3, 4'h3);
		op(8'h93, 2'h1, 4'h3, 4'h3);
		cmp("code_read", 8'h1, info.code_read);
		foreach (exts[i]) begin
			op(exts[i], 2'h1, 4'h3, 4'h3);
			cmp("ext_data", 8'h1, info.ext_data);
			cmp("ext_write", exts[i][4], info.ext_write);
		end
	endtask

	task automatic t_stack_bit();
		op(8'hc0, 2'h2, 4'h2, 4'h2);
		op(8'hd0, 2'h2, 4'h2, 4'h2);
		op(8'hc8, 2'h1, 4'h1, 4'h1);
		op(8'hc5, 2'h2, 4'h2, 4'h2);
		op(8'hc6, 2'h1, 4'h2, 4'h2);
		op(8'hd6, 2'h1, 4'h2, 4'h2);
		op(8'hc3, 2'h1, 4'h1, 4'h1);
		op(8'hd3, 2'h1, 4'h1, 4'h1);
		op(8'hb3, 2'h1, 4'h1, 4'h1);
		op(8'hb0, 2'h2, 4'h2, 4'h2);
		op(8'h92, 2'h2, 4'h2, 4'h2);
	endtask

	task automatic t_branch();
		op(8'h40, 2'h2, 4'h3, 4'h2);
		op(8'h50, 2'h2, 4'h3, 4'h2);
		op(8'h70, 2'h2, 4'h3, 4'h2);
		op(8'h60, 2'h2, 4'h3, 4'h2);
		cmp("rel_offset", 8'h1, info.rel_offset);
		op(8'h20, 2'h3, 4'h4, 4'h3);
		cmp("jb_clear", 8'h0, info.clears_bit);
		op(8'h10, 2'h3, 4'h4, 4'h3);
		cmp("clears_bit", 8'h1, info.clears_bit);
		op(8'hb5, 2'h3, 4'h4, 4'h3);
		op(8'hb8, 2'h3, 4'h4, 4'h3);
		op(8'hb6, 2'h3, 4'h5, 4'h4);
		op(8'hd8, 2'h2, 4'h3, 4'h2);
		op(8'hd5, 2'h3, 4'h4, 4'h3);
		op(8'h11, 2'h2, 4'h3, 4'h3);
		op(8'h01, 2'h2, 4'h3, 4'h3);
		op(8'h12, 2'h3, 4'h4, 4'h4);
		op(8'h02, 2'h3, 4'h4, 4'h4);
		cmp("long_jump_rel", 8'h0, info.rel_offset);
		op(8'h73, 2'h1, 4'h3, 4'h3);
		op(8'h22, 2'h1, 4'h5, 4'h5);
		op(8'h32, 2'h1, 4'h5, 4'h5);
		op(8'h80, 2'h2, 4'h3, 4'h3);
		cmp("short_jump_rel", 8'h1, info.rel_offset);
	endtask

	// spare opcode, back-to-back strobes, then a reset in mid-run
	task automatic t_misc();
		op(8'ha5, 2'h1, 4'h1, 4'h1);
		cmp("spare_ext", 8'h0, info.ext_data);
		req = 1'b1;
		req_op = 8'h84;
		@(negedge core_clk);
		req_op = 8'ha4;
		cmp("b2b_first", 8'h8, info.cyc_taken);
		@(negedge core_clk);
		req = 1'b0;
		cmp("b2b_second", 8'h4, info.cyc_taken);
		cmp("b2b_valid", 8'h1, info.valid);
		rst = 1'b1;
		@(negedge core_clk);
		rst = 1'b0;
		cmp("reset_info", 8'h0, {7'h0, |info});
		op(8'h00, 2'h1, 4'h1, 4'h1);
	endtask

	// ----------------------------------------------------------------
	// main sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		#400000;
		mismatches++;
		stop_test();
	end

	initial begin
		rst = 1'b1;
		req = 1'b0;
		req_op = 8'h00;
		mismatches = 0;
		checks = 0;
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		t_arith();
		t_move();
		t_stack_bit();
		t_branch();
		t_misc();
		stop_test();
	end
endmodule

// [testbench/mitd_fetch_model.sv]
// mitd_fetch_model.sv: fetch pipeline model that hands opcodes to the decoder
// assumes the bench changes req and req_op at the falling clock edge
`timescale 1ns/1ps
module mitd_fetch_model (
	input  wire logic       core_clk,
	input  wire logic       req,
	input  wire logic [7:0] req_op,
	output logic            op_valid,
	output logic [7:0]      opcode
);
	logic [7:0] junk = 8'h5a;

	// idle byte lane changes every cycle, so a stale opcode never passes
	always @(posedge core_clk) begin
		junk <= {junk[6:0], ~junk[7]};
	end

	// strobe and byte follow the request directly, as flash data would
	assign op_valid = req;
	assign opcode   = req ? req_op : junk;
endmodule
